// ===== dtm_defs.vh
// constants for the dual timer / event counter block
// assumes one 250 MHz reference clock and an AXI4-Lite master
`ifndef DTM_DEFS_VH
`define DTM_DEFS_VH

// register byte offsets
`define DTM_ADDR_CTRL      4'h0
`define DTM_ADDR_MODE      4'h4
`define DTM_ADDR_LOW0      4'h8
`define DTM_ADDR_HIGH0     4'hC
`define DTM_ADDR_LOW1      5'h10
`define DTM_ADDR_HIGH1     5'h14

// control register fields
`define DTM_CTRL_RUN0      4
`define DTM_CTRL_OVF0      5
`define DTM_CTRL_RUN1      6
`define DTM_CTRL_OVF1      7

// mode register fields, per timer nibble
`define DTM_MODE_QUAL      3
`define DTM_MODE_SRC       2

// mode codes
`define DTM_M_13BIT        2'b00
`define DTM_M_16BIT        2'b01
`define DTM_M_RELOAD       2'b10
`define DTM_M_SPLIT        2'b11

// reset values
`define DTM_CTRL_RST       8'h00
`define DTM_MODE_RST       8'h00

// timing
`define DTM_OSC_PER_PCYC   12
`define DTM_PCYC_W         4

// bus answers
`define DTM_RESP_OKAY      2'b00
`define DTM_RESP_SLVERR    2'b10

`endif

// ===== dtm_dual_timer.v
// two 16-bit timer / event counters with an AXI4-Lite register slave
// assumes count and gating pins are asynchronous to i_ref_clk
`timescale 1ns/1ps
`include "dtm_defs.vh"

module dtm_dual_timer (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // pins
  input  wire        i_count_pin_0,
  input  wire        i_count_pin_1,
  input  wire        i_gating_pin_0,
  input  wire        i_gating_pin_1,
  // interrupt service acknowledge
  input  wire        i_irq_ack_0,
  input  wire        i_irq_ack_1,
  output reg         o_irq_0,
  output reg         o_irq_1,
  output reg         o_baud_tick,
  // axi4-lite
  input  wire [7:0]  i_s_axi_awaddr,
  input  wire        i_s_axi_awvalid,
  output reg         o_s_axi_awready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  input  wire        i_s_axi_wvalid,
  output reg         o_s_axi_wready,
  output reg  [1:0]  o_s_axi_bresp,
  output reg         o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  input  wire [7:0]  i_s_axi_araddr,
  input  wire        i_s_axi_arvalid,
  output reg         o_s_axi_arready,
  output reg  [31:0] o_s_axi_rdata,
  output reg  [1:0]  o_s_axi_rresp,
  output reg         o_s_axi_rvalid,
  input  wire        i_s_axi_rready
);

  // ==========================================================
  // functions
  // ==========================================================
  // one count step: returns {ovf, high, low}
  function [16:0] dtm_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg   [5:0] pre;
    reg   [8:0] sum;
    begin
      pre = 6'd0;
      sum = 9'd0;
      case (mode)
        `DTM_M_13BIT: begin
          pre = {1'b0, lo[4:0]} + 6'd1;
          if (pre[5]) begin
            sum = {1'b0, hi} + 9'd1;
            dtm_step = {sum[8], sum[7:0], lo[7:5], pre[4:0]};
          end else begin
            dtm_step = {1'b0, hi, lo[7:5], pre[4:0]};
          end
        end
        `DTM_M_16BIT: begin
          dtm_step = {({hi, lo} == 16'hFFFF), {hi, lo} + 16'h0001};
        end
        `DTM_M_RELOAD: begin
          if (lo == 8'hFF) begin
            dtm_step = {1'b1, hi, hi};
          end else begin
            dtm_step = {1'b0, hi, lo + 8'h01};
          end
        end
        default: begin
          dtm_step = {1'b0, hi, lo};
        end
      endcase
    end
  endfunction

  // register address decode to a select code, 7 is unmapped
  function [2:0] dtm_dec;
    input [7:0] a;
    begin
      case (a)
        {4'h0, `DTM_ADDR_CTRL}:  dtm_dec = 3'd0;
        {4'h0, `DTM_ADDR_MODE}:  dtm_dec = 3'd1;
        {4'h0, `DTM_ADDR_LOW0}:  dtm_dec = 3'd2;
        {4'h0, `DTM_ADDR_HIGH0}: dtm_dec = 3'd3;
        {3'h0, `DTM_ADDR_LOW1}:  dtm_dec = 3'd4;
        {3'h0, `DTM_ADDR_HIGH1}: dtm_dec = 3'd5;
        default:                 dtm_dec = 3'd7;
      endcase
    end
  endfunction

  // ==========================================================
  // peripheral cycle strobe
  // ==========================================================
  reg [`DTM_PCYC_W-1:0] div_r;
  reg                   pcyc_r;

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      div_r  <= {`DTM_PCYC_W{1'b0}};
      pcyc_r <= 1'b0;
    end else if (div_r == `DTM_OSC_PER_PCYC - 1) begin
      div_r  <= {`DTM_PCYC_W{1'b0}};
      pcyc_r <= 1'b1;
    end else begin
      div_r  <= div_r + {{(`DTM_PCYC_W-1){1'b0}}, 1'b1};
      pcyc_r <= 1'b0;
    end
  end

  // ==========================================================
  // pin synchronisers: 3 flops, accept when 2nd and 3rd agree
  // ==========================================================
  reg [3:0] pin_s1_r;
  reg [3:0] pin_s2_r;
  reg [3:0] pin_s3_r;
  reg [3:0] pin_r;
  reg [1:0] cnt_smp_r;
  wire [1:0] fall;

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_s1_r  <= 4'h0;
      pin_s2_r  <= 4'h0;
      pin_s3_r  <= 4'h0;
      pin_r     <= 4'h0;
      cnt_smp_r <= 2'b00;
    end else begin
      pin_s1_r <= {i_gating_pin_1, i_gating_pin_0, i_count_pin_1, i_count_pin_0};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r    <= (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));
      if (pcyc_r) begin
        cnt_smp_r <= pin_r[1:0];
      end
    end
  end

  // high in previous sample, low in this one
  assign fall = cnt_smp_r & ~pin_r[1:0];

  // ==========================================================
  // registers
  // ==========================================================
  reg [7:0] mode_r;
  reg       run0_r;
  reg       run1_r;
  reg [7:0] low0_r;
  reg [7:0] high0_r;
  reg [7:0] low1_r;
  reg [7:0] high1_r;

  wire [1:0] m0 = mode_r[1:0];
  wire [1:0] m1 = mode_r[5:4];
  wire       split = (m0 == `DTM_M_SPLIT);

  // enable per timer
  wire en0  = run0_r & (~mode_r[`DTM_MODE_QUAL] | pin_r[2]);
  wire run1_eff = split ? 1'b1 : run1_r;
  wire en1  = run1_eff & (~mode_r[4+`DTM_MODE_QUAL] | pin_r[3]);
  wire inc0 = pcyc_r & en0 & (mode_r[`DTM_MODE_SRC] ? fall[0] : 1'b1);
  wire inc1 = pcyc_r & en1 & (mode_r[4+`DTM_MODE_SRC] ? fall[1] : 1'b1);
  wire inc0h = pcyc_r & run1_r & split;

  wire [16:0] st0 = dtm_step(m0, high0_r, low0_r);
  wire [16:0] st1 = dtm_step(m1, high1_r, low1_r);
  // split halves are plain 8-bit counters: reload zero, so they wrap
  wire [16:0] stl = dtm_step(`DTM_M_RELOAD, 8'h00, low0_r);
  wire [16:0] sth = dtm_step(`DTM_M_RELOAD, 8'h00, high0_r);

  wire        t0_ovf  = split ? (inc0 & stl[16]) : (inc0 & st0[16]);
  wire        t0h_ovf = inc0h & sth[16];
  wire        t1_ovf  = inc1 & st1[16] & (m1 != `DTM_M_SPLIT);

  // ==========================================================
  // bus write side
  // ==========================================================
  reg [7:0]  awaddr_r;
  reg        aw_held_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  reg        w_held_r;
  wire       wr_do = aw_held_r & w_held_r & ~o_s_axi_bvalid;
  wire [2:0] wsel  = dtm_dec(awaddr_r);
  wire       wbyte = wr_do & wstrb_r[0];
  wire [7:0] wd    = wdata_r[7:0];

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      awaddr_r        <= 8'h00;
      aw_held_r       <= 1'b0;
      wdata_r         <= 32'h0000_0000;
      wstrb_r         <= 4'h0;
      w_held_r        <= 1'b0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= `DTM_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid & o_s_axi_awready) begin
        awaddr_r        <= i_s_axi_awaddr;
        aw_held_r       <= 1'b1;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid & o_s_axi_wready) begin
        wdata_r        <= i_s_axi_wdata;
        wstrb_r        <= i_s_axi_wstrb;
        w_held_r       <= 1'b1;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_held_r      <= 1'b0;
        w_held_r       <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (wsel == 3'd7) ? `DTM_RESP_SLVERR : `DTM_RESP_OKAY;
      end
      if (o_s_axi_bvalid & i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // control, mode and flags
  // ==========================================================
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      mode_r  <= `DTM_MODE_RST;
      run0_r  <= 1'b0;
      run1_r  <= 1'b0;
      o_irq_0 <= 1'b0;
      o_irq_1 <= 1'b0;
    end else begin
      if (wbyte && wsel == 3'd1) begin
        mode_r <= wd;
      end
      if (wbyte && wsel == 3'd0) begin
        run0_r <= wd[`DTM_CTRL_RUN0];
        run1_r <= wd[`DTM_CTRL_RUN1];
      end
      // set wins over software write and service clear
      if (t0_ovf) begin
        o_irq_0 <= 1'b1;
      end else if (wbyte && wsel == 3'd0) begin
        o_irq_0 <= wd[`DTM_CTRL_OVF0];
      end else if (i_irq_ack_0) begin
        o_irq_0 <= 1'b0;
      end
      if (t0h_ovf | (t1_ovf & ~split)) begin
        o_irq_1 <= 1'b1;
      end else if (wbyte && wsel == 3'd0) begin
        o_irq_1 <= wd[`DTM_CTRL_OVF1];
      end else if (i_irq_ack_1) begin
        o_irq_1 <= 1'b0;
      end
    end
  end

  // ==========================================================
  // count bytes: software load has priority over counting
  // ==========================================================
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      low0_r      <= 8'h00;
      high0_r     <= 8'h00;
      low1_r      <= 8'h00;
      high1_r     <= 8'h00;
      o_baud_tick <= 1'b0;
    end else begin
      o_baud_tick <= t1_ovf;
      if (wbyte && wsel == 3'd2) begin
        low0_r <= wd;
      end else if (inc0) begin
        low0_r <= split ? stl[7:0] : st0[7:0];
      end
      if (wbyte && wsel == 3'd3) begin
        high0_r <= wd;
      end else if (inc0h) begin
        high0_r <= sth[7:0];
      end else if (inc0 & ~split) begin
        high0_r <= st0[15:8];
      end
      if (wbyte && wsel == 3'd4) begin
        low1_r <= wd;
      end else if (inc1) begin
        low1_r <= st1[7:0];
      end
      if (wbyte && wsel == 3'd5) begin
        high1_r <= wd;
      end else if (inc1) begin
        high1_r <= st1[15:8];
      end
    end
  end

  // ==========================================================
  // bus read side
  // ==========================================================
  reg [7:0] rd_byte;
  wire [2:0] rsel = dtm_dec(i_s_axi_araddr);

  always @* begin
    case (rsel)
      3'd0:    rd_byte = {o_irq_1, run1_r, o_irq_0, run0_r, 4'h0};
      3'd1:    rd_byte = mode_r;
      3'd2:    rd_byte = low0_r;
      3'd3:    rd_byte = high0_r;
      3'd4:    rd_byte = low1_r;
      3'd5:    rd_byte = high1_r;
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= `DTM_RESP_OKAY;
    end else if (i_s_axi_arvalid & o_s_axi_arready) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rdata   <= {24'h00_0000, rd_byte};
      o_s_axi_rresp   <= (rsel == 3'd7) ? `DTM_RESP_SLVERR : `DTM_RESP_OKAY;
    end else if (o_s_axi_rvalid & i_s_axi_rready) begin
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

endmodule // dtm_dual_timer

// ===== dtm_dual_timer_checker.sv
// checker for the dual timer bus answers and flag outputs
// assumes binding onto dtm_dual_timer, one clock, sync reset
`timescale 1ns/1ps
module dtm_checker (
  input wire        i_ref_clk,
  input wire        i_rst,
  input wire        o_irq_0,
  input wire        o_irq_1,
  input wire        i_irq_ack_0,
  input wire        i_irq_ack_1,
  input wire        o_baud_tick,
  input wire        i_s_axi_awvalid,
  input wire        o_s_axi_awready,
  input wire        i_s_axi_wvalid,
  input wire        o_s_axi_wready,
  input wire [1:0]  o_s_axi_bresp,
  input wire        o_s_axi_bvalid,
  input wire        i_s_axi_bready,
  input wire        i_s_axi_arvalid,
  input wire        o_s_axi_arready,
  input wire [31:0] o_s_axi_rdata,
  input wire        o_s_axi_rvalid,
  input wire        i_s_axi_rready
);
  // ==========================================================
  // assertions
  default clocking dc @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // cycles since the last baud tick, saturating
  logic [3:0] baud_gap_r;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      baud_gap_r <= 4'hF;
    end else if (o_baud_tick) begin
      baud_gap_r <= 4'h0;
    end else if (baud_gap_r != 4'hF) begin
      baud_gap_r <= baud_gap_r + 4'h1;
    end
  end
  AST_RST_CLEAR: assert property (@(posedge i_ref_clk) disable iff (1'b0) i_rst |=>
    !o_irq_0 && !o_irq_1 && !o_baud_tick && !o_s_axi_bvalid && !o_s_axi_rvalid)
    else $error("outputs not cleared by reset");
  AST_W_ANSWER: assert property (i_s_axi_awvalid && o_s_axi_awready &&
    i_s_axi_wvalid && o_s_axi_wready |-> ##2 o_s_axi_bvalid) else $error("no write answer");
  AST_B_STANDS: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped");
  AST_AW_REFUSE: assert property (i_s_axi_awvalid && o_s_axi_awready |=>
    !o_s_axi_awready) else $error("second write address taken");
  AST_R_ANSWER: assert property (i_s_axi_arvalid && o_s_axi_arready |=>
    o_s_axi_rvalid) else $error("no read answer");
  AST_R_STANDS: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read answer dropped");
  AST_R_UPPER: assert property (o_s_axi_rvalid |->
    o_s_axi_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  AST_BAUD_STROBE: assert property (o_baud_tick |-> baud_gap_r >= 4'hB)
    else $error("baud ticks too close");
  AST_IRQ0_HOLD: assert property (o_irq_0 && !i_irq_ack_0 && o_s_axi_awready &&
    o_s_axi_wready |=> o_irq_0) else $error("flag 0 lost");
  AST_IRQ1_HOLD: assert property (o_irq_1 && !i_irq_ack_1 && o_s_axi_awready &&
    o_s_axi_wready |=> o_irq_1) else $error("flag 1 lost");
endmodule // dtm_checker
bind dtm_dual_timer dtm_checker chk_u (.*);

// ===== dtm_pin_model.sv
// drives the count and gating pins of the dual timer
// assumes the timer samples each pin once every twelve clocks
`timescale 1ns/1ps
module dtm_pin_model (
  input  wire i_ref_clk,
  output reg  o_count_pin_0,
  output reg  o_count_pin_1,
  output reg  o_gating_pin_0,
  output reg  o_gating_pin_1
);
  // ==========================================================
  // pin sequences
  initial begin
    o_count_pin_0  = 1'b1;
    o_count_pin_1  = 1'b1;
    o_gating_pin_0 = 1'b1;
    o_gating_pin_1 = 1'b1;
  end
  task fall(input integer k);
    begin
      @(posedge i_ref_clk);
      if (k == 1) o_count_pin_1 <= 1'b0;
      else o_count_pin_0 <= 1'b0;
      repeat (16) @(posedge i_ref_clk);
      o_count_pin_0 <= 1'b1;
      o_count_pin_1 <= 1'b1;
      repeat (16) @(posedge i_ref_clk);
    end
  endtask
  task gate(input integer k, input logic v);
    begin
      @(posedge i_ref_clk);
      if (k == 1) o_gating_pin_1 <= v;
      else o_gating_pin_0 <= v;
      repeat (4) @(posedge i_ref_clk);
    end
  endtask
endmodule // dtm_pin_model

// ===== tb_dual_timer_event_counter.sv
// self-checking bench for the dual timer over its register bus
// assumes dtm_pin_model drives the pins, no interrupt controller
`timescale 1ns/1ps
module tb_dual_timer_event_counter;
  logic        clk = 0, rst = 1, ack0 = 0, ack1 = 0;
  logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [1:0]  resp, wresp;
  wire         awr, wrd, bv, arr, rv, irq0, irq1, baud, cp0, cp1, gp0, gp1;
  wire  [1:0]  br, rr;
  wire  [31:0] rdd;
  integer      failures = 0, comparisons = 0, n, i;
  always #2 clk = ~clk;
  dtm_dual_timer dut_u (.i_ref_clk(clk), .i_rst(rst), .i_count_pin_0(cp0),
    .i_count_pin_1(cp1), .i_gating_pin_0(gp0), .i_gating_pin_1(gp1), .i_irq_ack_0(ack0),
    .i_irq_ack_1(ack1), .o_irq_0(irq0), .o_irq_1(irq1), .o_baud_tick(baud),
    .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd),
    .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .i_s_axi_araddr(ara),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdd),
    .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry));
  dtm_pin_model pins_u (.i_ref_clk(clk), .o_count_pin_0(cp0), .o_count_pin_1(cp1),
    .o_gating_pin_0(gp0), .o_gating_pin_1(gp1));
  // ==========================================================
  // tasks
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      comparisons++;
      if (got !== exp) begin
        failures++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic ad, dd;
    begin
      ad = 0;
      dd = 0;
      @(posedge clk);
      awa <= a;
      wd <= {24'h00_0000, d};
      awv <= 1;
      wv <= 1;
      bry <= 1;
      while (!(ad && dd)) begin
        @(posedge clk);
        if (awr) awv <= 0;
        if (wrd) wv <= 0;
        ad = ad | awr;
        dd = dd | wrd;
      end
      while (bv !== 1'b1) @(posedge clk);
      wresp = br;
      bry <= 0;
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    begin
      @(posedge clk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      @(posedge clk);
      while (arr !== 1'b1) @(posedge clk);
      arv <= 0;
      @(posedge clk);
      while (rv !== 1'b1) @(posedge clk);
      rry <= 0;
      resp = rr;
      chk($sformatf("reg %h", a), {24'h00_0000, exp}, rdd);
    end
  endtask
  task wait_on(input integer k);
    begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((k == 0 ? irq0 : k == 1 ? irq1 : baud) !== 1'b1 && n < 40);
    end
  endtask
  task ack(input integer k);
    begin
      @(posedge clk);
      if (k == 1) ack1 <= 1;
      else ack0 <= 1;
      @(posedge clk);
      ack0 <= 0;
      ack1 <= 0;
      @(posedge clk);
      chk("flag after service", 0, {31'h0, k == 1 ? irq1 : irq0});
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("ERROR watchdog expected end seen hang");
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h2C, 8'h00);
    chk("unmapped resp", 32'h0000_0002, {30'h0, resp});
    wr(8'h2C, 8'h55);
    chk("unmapped write resp", 32'h0000_0002, {30'h0, wresp});
    for (i = 0; i < 4; i++) wr(8'(8 + 4 * i), 8'(8'h33 + 8'h11 * i));
    for (i = 0; i < 4; i++) rd(8'(8 + 4 * i), 8'(8'h33 + 8'h11 * i));
    $display("test registers done");
    wr(8'h04, 8'h01);
    wr(8'h08, 8'hFE);
    wr(8'h0C, 8'hFF);
    wr(8'h00, 8'h10);
    wait_on(0);
    chk("flag 0", 1, {31'h0, irq0});
    ack(0);
    wr(8'h00, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h0C, 8'h00);
    $display("test cascade done");
    wr(8'h04, 8'h20);
    wr(8'h10, 8'hFE);
    wr(8'h14, 8'hF0);
    wr(8'h00, 8'h40);
    wait_on(1);
    chk("flag 1", 1, {31'h0, irq1});
    ack(1);
    wr(8'h00, 8'h00);
    rd(8'h10, 8'hF0);
    rd(8'h14, 8'hF0);
    $display("test reload done");
    wr(8'h04, 8'h04);
    wr(8'h08, 8'hFF);
    wr(8'h0C, 8'h10);
    wr(8'h00, 8'h10);
    pins_u.fall(0);
    wr(8'h00, 8'h00);
    rd(8'h08, 8'hE0);
    rd(8'h0C, 8'h11);
    $display("test prescaled counter done");
    wr(8'h04, 8'h0D);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h10);
    pins_u.gate(0, 0);
    pins_u.fall(0);
    rd(8'h08, 8'h00);
    pins_u.gate(0, 1);
    pins_u.fall(0);
    rd(8'h08, 8'h01);
    $display("test gating done");
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h77);
    wr(8'h0C, 8'hFF);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h33);
    wr(8'h00, 8'h40);
    wait_on(1);
    chk("split high flag", 1, {31'h0, irq1});
    chk("split low flag", 0, {31'h0, irq0});
    rd(8'h0C, 8'h00);
    rd(8'h10, 8'h77);
    rd(8'h08, 8'h00);
    $display("test split done");
    ack(1);
    wr(8'h14, 8'hFF);
    wr(8'h10, 8'hFF);
    wr(8'h04, 8'h23);
    wait_on(2);
    chk("baud seen", 1, {31'h0, baud});
    wait_on(2);
    chk("baud spacing", 12, n);
    $display("test baud done");
    give_verdict;
  end
endmodule // tb_dual_timer_event_counter
